/* design/fault_monitor_pkg.sv */
// Shared register map, field layout and reset values for the LED sink fault monitor.
package fault_monitor_pkg;

    // =========================================================================
    // Register bus geometry.
    // =========================================================================
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int SINK_N = 7;

    // =========================================================================
    // Register offsets.
    // =========================================================================
    localparam logic [7:0] OFS_OPEN_FAULT_STATUS  = 8'hb0;
    localparam logic [7:0] OFS_SHORT_FAULT_STATUS = 8'hb1;
    localparam logic [7:0] OFS_FAULT_DETECT_EN    = 8'hb2;
    localparam logic [7:0] OFS_OVERVOLTAGE_SEL    = 8'hb3;
    localparam logic [7:0] OFS_LIVE_FAULTS        = 8'hb4;
    localparam logic [7:0] OFS_BOOST_STATE        = 8'hb5;

    // =========================================================================
    // Sink bit positions inside both status bytes.
    // =========================================================================
    localparam int BIT_HIGH_VOLTAGE_STRING_ONE = 0;
    localparam int BIT_HIGH_VOLTAGE_STRING_TWO = 1;
    localparam int BIT_INDICATOR_SINK_ONE      = 2;
    localparam int BIT_INDICATOR_SINK_FIVE     = 6;

    // =========================================================================
    // Fault enable fields and reset values.
    // =========================================================================
    localparam int BIT_OPEN_EN  = 0;
    localparam int BIT_SHORT_EN = 1;
    localparam logic [1:0] FAULT_EN_RESET = 2'h0;

    // =========================================================================
    // Overvoltage threshold codes.
    // =========================================================================
    localparam logic [1:0] OVL_16V = 2'h0;
    localparam logic [1:0] OVL_24V = 2'h1;
    localparam logic [1:0] OVL_32V = 2'h2;
    localparam logic [1:0] OVL_40V = 2'h3;
    localparam logic [1:0] OVL_RESET = OVL_16V;

    // =========================================================================
    // Boost state readback fields.
    // =========================================================================
    localparam int BIT_BOOST_ON      = 0;
    localparam int BIT_BOOST_CURLIM  = 1;
    localparam int BIT_BOOST_OVHOLD  = 2;

endpackage : fault_monitor_pkg

/* design/boost_switch_gate.sv */
// Boost power-switch gating by the peak current limit and the overvoltage threshold.
`timescale 1ns/1ns
`default_nettype none

module boost_switch_gate (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic hardware_enable_pin,
    input  wire logic switch_request,
    input  wire logic period_start,
    input  wire logic peak_current_hit,
    input  wire logic output_at_limit,
    input  wire logic output_below_hyst,
    output logic      switch_on,
    output logic      current_limited,
    output logic      overvoltage_held
);

    // =========================================================================
    // State.
    // =========================================================================
    typedef struct packed {
        logic cl_hold;
        logic ov_hold;
        logic sw_on;
    } gate_state_t;

    gate_state_t st_r;
    gate_state_t st_nxt;

    // =========================================================================
    // Next state.
    // =========================================================================
    // A limit hit in the same cycle as a new period wins, so the new period stays blocked.
    always_comb begin
        st_nxt = st_r;
        st_nxt.cl_hold = peak_current_hit | (st_r.cl_hold & ~period_start); // see R7
        st_nxt.ov_hold = output_at_limit | (st_r.ov_hold & ~output_below_hyst); // see R8
        st_nxt.sw_on   = switch_request & ~st_nxt.cl_hold & ~st_nxt.ov_hold; // see R7 R8
        if (!hardware_enable_pin) begin
            st_nxt = '0;
        end
    end

    // Register the whole state.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign switch_on        = st_r.sw_on;
    assign current_limited  = st_r.cl_hold;
    assign overvoltage_held = st_r.ov_hold;

endmodule : boost_switch_gate

`default_nettype wire

/* design/led_sink_fault_monitor.sv */
// Fault readback registers, detection enables and boost gating for the LED sink driver.
//
// Contract
// R1: Open status byte: bit0-1 high-voltage strings, bits2-6 indicator sinks, bit7 zero.
// R2: An open flag reads 0 normally and 1 once an open was detected.
// R3: Short status byte uses the same bit mapping, bit7 zero.
// R4: A short flag reads 0 normally and 1 once a short was detected.
// R5: Enable bit1 gates short detection, reset value disabled.
// R6: Enable bit0 gates open detection, reset value disabled; bits7-2 unused.
// R7: Peak current limit holds the switch off for the rest of the period.
// R8: Overvoltage holds the switch off until output falls below hysteresis.
// R9: Overvoltage threshold selects 16/24/32/40 V, defaults 16 V after any reset.
// R10: Host raises the threshold after reset for strings over four LEDs.
// R11: A disabled fault type never sets flags, so they read 0.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
`default_nettype none

module led_sink_fault_monitor (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        hardware_enable_pin,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [6:0]  open_detect,
    input  wire logic [6:0]  short_detect,
    input  wire logic        switch_request,
    input  wire logic        period_start,
    input  wire logic        peak_current_hit,
    input  wire logic        output_at_limit,
    input  wire logic        output_below_hyst,
    output logic             boost_switch_on,
    output logic      [1:0]  overvoltage_limit_sel
);

    // =========================================================================
    // Register index decode.
    // =========================================================================
    typedef enum {
        REG_NONE,
        REG_OPEN,
        REG_SHORT,
        REG_EN,
        REG_OVL,
        REG_LIVE,
        REG_BOOST
    } reg_sel_t;

    // Shared by the write path and the read path so both agree on the map.
    function automatic reg_sel_t decode(input logic [7:0] addr);
        reg_sel_t sel;
        case (addr)
            fault_monitor_pkg::OFS_OPEN_FAULT_STATUS: begin
                sel = REG_OPEN;
            end
            fault_monitor_pkg::OFS_SHORT_FAULT_STATUS: begin
                sel = REG_SHORT;
            end
            fault_monitor_pkg::OFS_FAULT_DETECT_EN: begin
                sel = REG_EN;
            end
            fault_monitor_pkg::OFS_OVERVOLTAGE_SEL: begin
                sel = REG_OVL;
            end
            fault_monitor_pkg::OFS_LIVE_FAULTS: begin
                sel = REG_LIVE;
            end
            fault_monitor_pkg::OFS_BOOST_STATE: begin
                sel = REG_BOOST;
            end
            default: begin
                sel = REG_NONE;
            end
        endcase
        return sel;
    endfunction : decode

    // Detector qualification, used for both fault types.
    function automatic logic [6:0] qualify(input logic [6:0] det, input logic en);
        return en ? det : 7'h00;
    endfunction : qualify

    // =========================================================================
    // State.
    // =========================================================================
    typedef struct packed {
        logic [6:0] open_flags;
        logic [6:0] short_flags;
        logic       open_en;
        logic       short_en;
        logic [1:0] ovl_sel;
        logic [7:0] rdata;
    } mon_state_t;

    mon_state_t st_r;
    mon_state_t st_nxt;

    reg_sel_t   wr_sel;
    reg_sel_t   rd_sel;
    logic [6:0] open_q;
    logic [6:0] short_q;
    logic [6:0] open_set;
    logic [6:0] short_set;
    logic [6:0] open_clr;
    logic [6:0] short_clr;
    logic       gate_cl;
    logic       gate_ov;

    assign wr_sel = reg_wr ? decode(reg_addr) : REG_NONE;
    assign rd_sel = reg_rd ? decode(reg_addr) : REG_NONE;

    // Qualified detector words; a bit-select of a call result is not legal, so name them first.
    assign open_q  = qualify(open_detect, st_r.open_en); // see R11
    assign short_q = qualify(short_detect, st_r.short_en); // see R11

    // =========================================================================
    // Per-sink flag set and clear terms.
    // =========================================================================
    // Flags are sticky so a brief fault is not missed between polls; reading a status
    // byte clears it, but a detection in that same cycle still sets the flag.
    genvar g;
    generate
        for (g = 0; g < fault_monitor_pkg::SINK_N; g = g + 1) begin : g_sink
            assign open_set[g]  = open_q[g]; // see R2 R11
            assign short_set[g] = short_q[g]; // see R4 R11
            assign open_clr[g]  = (rd_sel == REG_OPEN) | ~st_r.open_en; // see R11
            assign short_clr[g] = (rd_sel == REG_SHORT) | ~st_r.short_en; // see R11
        end
    endgenerate

    // =========================================================================
    // Next state: flags, register writes and read data.
    // =========================================================================
    always_comb begin
        st_nxt = st_r;

        // Set wins over clear for every hardware-set flag.
        st_nxt.open_flags  = open_set | (st_r.open_flags & ~open_clr); // see R1 R2
        st_nxt.short_flags = short_set | (st_r.short_flags & ~short_clr); // see R3 R4

        // Writes; status registers are read-only and ignore writes.
        case (wr_sel)
            REG_EN: begin
                st_nxt.open_en  = reg_wdata[fault_monitor_pkg::BIT_OPEN_EN]; // see R6
                st_nxt.short_en = reg_wdata[fault_monitor_pkg::BIT_SHORT_EN]; // see R5
            end
            REG_OVL: begin
                st_nxt.ovl_sel = reg_wdata[1:0]; // see R9
            end
            default: begin
            end
        endcase

        // Read data stands for one cycle only; unmapped addresses read zero.
        case (rd_sel)
            REG_OPEN: begin
                st_nxt.rdata = {1'b0, st_r.open_flags}; // see R1
            end
            REG_SHORT: begin
                st_nxt.rdata = {1'b0, st_r.short_flags}; // see R3
            end
            REG_EN: begin
                st_nxt.rdata = {6'h00, st_r.short_en, st_r.open_en}; // see R5 R6
            end
            REG_OVL: begin
                st_nxt.rdata = {6'h00, st_r.ovl_sel};
            end
            REG_LIVE: begin
                st_nxt.rdata = {1'b0, qualify(open_detect | short_detect, 1'b1)};
            end
            REG_BOOST: begin
                st_nxt.rdata = {5'h00, gate_ov, gate_cl, boost_switch_on};
            end
            default: begin
                st_nxt.rdata = 8'h00;
            end
        endcase

        // Dropping the hardware enable returns everything to defaults,
        // which is why the host must reprogram the threshold afterwards.
        if (!hardware_enable_pin) begin
            st_nxt.open_flags  = 7'h00;
            st_nxt.short_flags = 7'h00;
            st_nxt.open_en     = fault_monitor_pkg::FAULT_EN_RESET[fault_monitor_pkg::BIT_OPEN_EN]; // see R6
            st_nxt.short_en    = fault_monitor_pkg::FAULT_EN_RESET[fault_monitor_pkg::BIT_SHORT_EN]; // see R5
            st_nxt.ovl_sel     = fault_monitor_pkg::OVL_RESET; // see R9 R10
        end
    end

    // =========================================================================
    // State register.
    // =========================================================================
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_r         <= '0;
            st_r.ovl_sel <= fault_monitor_pkg::OVL_RESET; // see R9
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata             = st_r.rdata;
    assign overvoltage_limit_sel = st_r.ovl_sel;

    // =========================================================================
    // Boost switch gating.
    // =========================================================================
    boost_switch_gate u_gate (
        .clock               (clock),
        .sys_rst             (sys_rst),
        .hardware_enable_pin (hardware_enable_pin),
        .switch_request      (switch_request),
        .period_start        (period_start),
        .peak_current_hit    (peak_current_hit),
        .output_at_limit     (output_at_limit),
        .output_below_hyst   (output_below_hyst),
        .switch_on           (boost_switch_on),
        .current_limited     (gate_cl),
        .overvoltage_held    (gate_ov)
    );

endmodule : led_sink_fault_monitor

`default_nettype wire

/* test/led_sink_fault_monitor_monitor.sv */
// Concurrent port checks for the LED sink fault monitor.
`timescale 1ns/1ns
`default_nettype none

// =============================================================
// Port checker.
// =============================================================
module fault_checker (
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic       hardware_enable_pin,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [6:0] open_detect,
    input wire logic [6:0] short_detect,
    input wire logic       switch_request,
    input wire logic       period_start,
    input wire logic       peak_current_hit,
    input wire logic       output_at_limit,
    input wire logic       output_below_hyst,
    input wire logic       boost_switch_on,
    input wire logic [1:0] overvoltage_limit_sel
);
    localparam logic [7:0] A_OPEN = fault_monitor_pkg::OFS_OPEN_FAULT_STATUS;
    localparam logic [7:0] A_SHORT = fault_monitor_pkg::OFS_SHORT_FAULT_STATUS;
    localparam logic [7:0] A_OVL = fault_monitor_pkg::OFS_OVERVOLTAGE_SEL;
    logic en_wr;
    logic rd_open;
    logic rd_short;

    // Strobe decodes; an enable write only sticks while the enable pin is high.
    assign en_wr = reg_wr && hardware_enable_pin && reg_addr == fault_monitor_pkg::OFS_FAULT_DETECT_EN;
    assign rd_open = reg_rd && reg_addr == A_OPEN;
    assign rd_short = reg_rd && reg_addr == A_SHORT;

    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_open_top; rd_open |=> !reg_rdata[7]; endproperty
    a_open_top: assert property (p_open_top) else $error("open bit7 set");
    property p_short_top; rd_short |=> !reg_rdata[7]; endproperty
    a_short_top: assert property (p_short_top) else $error("short bit7 set");
    // The middle cycle must carry no write, else the enable could come back.
    property p_open_off; en_wr && !reg_wdata[0] ##1 !reg_wr ##1 rd_open |=> reg_rdata[6:0] == 7'h00; endproperty
    a_open_off: assert property (p_open_off) else $error("open flag while off");
    property p_short_off; en_wr && !reg_wdata[1] ##1 !reg_wr ##1 rd_short |=> reg_rdata[6:0] == 7'h00; endproperty
    a_short_off: assert property (p_short_off) else $error("short flag while off");
    property p_open_set;
        en_wr && reg_wdata[0] ##1 (!reg_wr && hardware_enable_pin && open_detect[0])
            ##1 (rd_open && hardware_enable_pin) |=> reg_rdata[0];
    endproperty
    a_open_set: assert property (p_open_set) else $error("open flag missed");
    property p_cl; peak_current_hit ##1 !period_start |=> !boost_switch_on; endproperty
    a_cl: assert property (p_cl) else $error("switch on in limited period");
    property p_ov; output_at_limit ##1 !output_below_hyst |=> !boost_switch_on; endproperty
    a_ov: assert property (p_ov) else $error("switch on above hysteresis");
    property p_on;
        switch_request && period_start && output_below_hyst && !peak_current_hit && !output_at_limit
            && hardware_enable_pin |=> boost_switch_on;
    endproperty
    a_on: assert property (p_on) else $error("switch not on");
    property p_hw; !hardware_enable_pin |=> !boost_switch_on && overvoltage_limit_sel == 2'h0; endproperty
    a_hw: assert property (p_hw) else $error("no default on enable pin low");
    property p_sel; reg_wr && hardware_enable_pin && reg_addr == A_OVL |=> overvoltage_limit_sel == $past(reg_wdata[1:0]); endproperty
    a_sel: assert property (p_sel) else $error("threshold not taken");

    // Main scenarios reached.
    c_open: cover property (rd_open ##1 reg_rdata != 8'h00);
    c_on: cover property (boost_switch_on);
    c_sel: cover property (overvoltage_limit_sel == fault_monitor_pkg::OVL_40V);
endmodule : fault_checker

bind led_sink_fault_monitor fault_checker fault_checker_inst (.clock, .sys_rst, .hardware_enable_pin,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .open_detect, .short_detect, .switch_request,
    .period_start, .peak_current_hit, .output_at_limit, .output_below_hyst, .boost_switch_on,
    .overvoltage_limit_sel);
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the LED sink fault monitor.
`timescale 1ns/1ns
`default_nettype none

// =============================================================
// Bench top.
// =============================================================
module testbench;
    logic       clock = 1'b0;
    logic       sys_rst = 1'b1;
    logic       hardware_enable_pin = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [6:0] open_detect = 7'h00;
    logic [6:0] short_detect = 7'h00;
    logic       switch_request = 1'b1;
    logic       period_start = 1'b0;
    logic       peak_current_hit = 1'b0;
    logic       output_at_limit = 1'b0;
    logic       output_below_hyst = 1'b1;
    logic       boost_switch_on;
    logic [1:0] overvoltage_limit_sel;
    int         fail_count = 0;
    int         cmp_count = 0;
    int         cycles = 0;

    // Clock of 100 ns period.
    always #50 clock = ~clock;

    led_sink_fault_monitor led_sink_fault_monitor_inst (.clock, .sys_rst, .hardware_enable_pin,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .open_detect, .short_detect, .switch_request,
        .period_start, .peak_current_hit, .output_at_limit, .output_below_hyst, .boost_switch_on,
        .overvoltage_limit_sel);

    // =============================================================
    // Shared tasks.
    // =============================================================
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, e);
    endtask : rdc

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    // =============================================================
    // Scenarios.
    // =============================================================
    task automatic t_regs;
        rdc(8'hb0, 8'h00);
        rdc(8'hb1, 8'h00);
        rdc(8'hb2, 8'h00);
        wr(8'hb0, 8'hff);
        rdc(8'hb0, 8'h00);
        wr(8'h10, 8'hff);
        rdc(8'h10, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(fault_monitor_pkg::OFS_OVERVOLTAGE_SEL, 8'(c));
            #1 check({6'h00, overvoltage_limit_sel}, 8'(c));
        end
        wr(8'hb2, 8'h03);
        @(posedge clock) hardware_enable_pin <= 1'b0;
        @(posedge clock) hardware_enable_pin <= 1'b1;
        #1 check({6'h00, overvoltage_limit_sel}, 8'h00);
        rdc(8'hb2, 8'h00);
        // Long strings need a higher threshold after every enable-pin reset.
        wr(fault_monitor_pkg::OFS_OVERVOLTAGE_SEL, 8'h02);
        #1 check({6'h00, overvoltage_limit_sel}, 8'h02);
        $display("test regs done");
    endtask : t_regs

    // Flags stay set while the detector is high; a read clears them once it drops.
    task automatic t_open;
        @(posedge clock) open_detect <= 7'h7f;
        rdc(8'hb0, 8'h00);
        wr(8'hb2, 8'h01);
        rdc(8'hb0, 8'h7f);
        rdc(fault_monitor_pkg::OFS_LIVE_FAULTS, 8'h7f);
        @(posedge clock) open_detect <= 7'h00;
        rdc(8'hb0, 8'h7f);
        rdc(8'hb0, 8'h00);
        $display("test open done");
    endtask : t_open

    task automatic t_short;
        wr(8'hb2, 8'hff);
        rdc(8'hb2, 8'h03);
        for (int i = 0; i < 7; i++) begin
            @(posedge clock) short_detect <= 7'(1 << i);
            @(posedge clock) short_detect <= 7'h00;
            rdc(8'hb1, 8'(1 << i));
        end
        @(posedge clock) open_detect <= 7'h7f;
        short_detect <= 7'h7f;
        wr(8'hb2, 8'h02);
        rdc(8'hb0, 8'h00);
        wr(8'hb2, 8'h00);
        rdc(8'hb1, 8'h00);
        @(posedge clock) open_detect <= 7'h00;
        short_detect <= 7'h00;
        $display("test short done");
    endtask : t_short

    task automatic t_boost;
        tick(2);
        check({7'h00, boost_switch_on}, 8'h01);
        @(posedge clock) peak_current_hit <= 1'b1;
        @(posedge clock) peak_current_hit <= 1'b0;
        tick(3);
        check({7'h00, boost_switch_on}, 8'h00);
        @(posedge clock) period_start <= 1'b1;
        @(posedge clock) period_start <= 1'b0;
        tick(1);
        check({7'h00, boost_switch_on}, 8'h01);
        @(posedge clock) output_at_limit <= 1'b1;
        output_below_hyst <= 1'b0;
        @(posedge clock) output_at_limit <= 1'b0;
        tick(3);
        check({7'h00, boost_switch_on}, 8'h00);
        rdc(fault_monitor_pkg::OFS_BOOST_STATE, 8'(1 << fault_monitor_pkg::BIT_BOOST_OVHOLD));
        @(posedge clock) output_below_hyst <= 1'b1;
        tick(2);
        check({7'h00, boost_switch_on}, 8'h01);
        // A limit hit in the very cycle a period starts still blocks that period.
        @(posedge clock) peak_current_hit <= 1'b1;
        period_start <= 1'b1;
        @(posedge clock) peak_current_hit <= 1'b0;
        period_start <= 1'b0;
        tick(2);
        check({7'h00, boost_switch_on}, 8'h00);
        rdc(fault_monitor_pkg::OFS_BOOST_STATE, 8'(1 << fault_monitor_pkg::BIT_BOOST_CURLIM));
        $display("test boost done");
    endtask : t_boost

    // A hang is cut short well beyond the roughly 115 cycles the run needs.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // Main sequence.
    initial begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        t_regs();
        t_open();
        t_short();
        t_boost();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
